// File: design/ddc_config_bank.sv
// Datapath interface and output scale configuration registers with the
// input formatting, mixer gain and alarm shutdown logic they steer.
// Assumes alarm levels and sample bus come from logic on mclk; serial pins
// and the transmit-enable pin are asynchronous and resynchronised here.

////////////////////////////////////////////////////////////////////////////
module ddc_config_bank (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sif_sclk,
  input  wire logic        sif_sden_n,
  input  wire logic        sif_sdio_i,
  output logic             sif_sdio_o,
  output logic             sif_sdio_oe,
  output logic             sif_sdo,
  output logic             sif_sdo_oe,
  input  wire logic        txenable_pin,
  input  wire logic        dacclk_gone,
  input  wire logic        dataclk_gone,
  input  wire logic        fifo_collision,
  input  wire logic [15:0] data_bus,
  input  wire logic        data_strobe,
  input  wire logic        frame_start,
  output logic [15:0]      dac_i_out,
  output logic [15:0]      dac_q_out,
  output logic             output_shutdown,
  output logic             tx_enable,
  output logic             word_wide_input_sel,
  output logic             four_wire_port_sel,
  output logic             mixer_enable,
  output logic             mixer_gain_6db,
  output logic             nco_enable,
  output logic [4:0]       full_scale_steps
);

  typedef struct packed {
    logic [15:0] dpath;
    logic [15:0] scale;
    logic        txp_m;
    logic        txp_s;
    logic [7:0]  hi_byte;
    logic        byte_phase;
    logic        q_chan;
    logic        shut;
    logic        txen;
    logic [15:0] i_out;
    logic [15:0] q_out;
    logic [4:0]  steps;
  } ddc_bank_t;

  ddc_bank_t   s_r;
  ddc_bank_t   s_nxt;
  logic        wr_pulse;
  logic [6:0]  sp_addr;
  logic [15:0] sp_wdata;
  logic [15:0] rdata;
  logic [15:0] word;
  logic        word_done;
  logic [15:0] sample;

  ////////////////////////////////////////////////////////////////////////////
  // Bit order reversal of the input bus
  function automatic logic [15:0] ddc_reverse(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int k = 0; k < 16; k++) begin
      r[k] = w[15 - k];
    end
    return r;
  endfunction

  // Doubling with saturation, in two's complement
  function automatic logic [15:0] ddc_double(input logic [15:0] w);
    logic [15:0] r;
    r = {w[14:0], 1'b0};
    if (w[15] != w[14]) begin
      r = w[15] ? ddc_pkg::NEG_FULL : ddc_pkg::POS_FULL;
    end
    return r;
  endfunction

  // Merge writable bits of a write with reserved reset bits
  function automatic logic [15:0] ddc_merge(input logic [15:0] w,
                                            input logic [15:0] mask,
                                            input logic [15:0] rst);
    return (w & mask) | (rst & ~mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped addresses read as zero
  always_comb begin
    if (sp_addr == ddc_pkg::ADR_DATAPATH_CTRL) begin
      rdata = s_r.dpath;
    end else if (sp_addr == ddc_pkg::ADR_SCALE_TX_CTRL) begin
      rdata = s_r.scale;
    end else begin
      rdata = 16'h0000;
    end
  end

  ddc_sif_port u_sif (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .sclk      (sif_sclk),
    .sden_n    (sif_sden_n),
    .sdio_i    (sif_sdio_i),
    .four_wire (s_r.dpath[ddc_pkg::BIT_FOUR_WIRE]),
    .rdata     (rdata),
    .sdio_o    (sif_sdio_o),
    .sdio_oe   (sif_sdio_oe),
    .sdo       (sif_sdo),
    .sdo_oe    (sif_sdo_oe),
    .wr_pulse  (wr_pulse),
    .addr      (sp_addr),
    .wdata     (sp_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt       = s_r;
    s_nxt.txp_m = txenable_pin;
    s_nxt.txp_s = s_r.txp_m;
    word        = 16'h0000;
    word_done   = 1'b0;
    sample      = 16'h0000;

    // Register writes; reserved bits forced back to reset values
    if (wr_pulse) begin
      if (sp_addr == ddc_pkg::ADR_DATAPATH_CTRL) begin
        s_nxt.dpath = ddc_merge(sp_wdata, ddc_pkg::WMASK_DATAPATH_CTRL,
                                ddc_pkg::RST_DATAPATH_CTRL);
      end else if (sp_addr == ddc_pkg::ADR_SCALE_TX_CTRL) begin
        s_nxt.scale = ddc_merge(sp_wdata, ddc_pkg::WMASK_SCALE_TX_CTRL,
                                ddc_pkg::RST_SCALE_TX_CTRL);
      end
    end

    // Shutdown only acts for alarms whose enable is set; no other mask
    // gates the alarm inputs
    s_nxt.shut =
      (dacclk_gone    & s_r.dpath[ddc_pkg::BIT_DACCLK_SHUT])    |
      (dataclk_gone   & s_r.dpath[ddc_pkg::BIT_DATACLK_SHUT])   |
      (fifo_collision & s_r.dpath[ddc_pkg::BIT_COLLISION_SHUT]);

    s_nxt.txen = s_r.scale[ddc_pkg::BIT_SIF_TXENA] | s_r.txp_s;
    s_nxt.steps = {1'b0, s_r.scale[ddc_pkg::BIT_SCALE_HI:
                                   ddc_pkg::BIT_SCALE_LO]} + 5'h01;

    // Input assembly: byte mode takes high byte first, then low byte
    if (frame_start) begin
      s_nxt.q_chan     = 1'b0;
      s_nxt.byte_phase = 1'b0;
    end else if (data_strobe) begin
      if (s_r.dpath[ddc_pkg::BIT_WORD_WIDE]) begin
        word      = data_bus;
        word_done = 1'b1;
      end else if (!s_r.byte_phase) begin
        s_nxt.hi_byte    = data_bus[7:0];
        s_nxt.byte_phase = 1'b1;
      end else begin
        word             = {s_r.hi_byte, data_bus[7:0]};
        word_done        = 1'b1;
        s_nxt.byte_phase = 1'b0;
      end
    end

    if (word_done) begin
      sample = word;
      if (s_r.dpath[ddc_pkg::BIT_REV_BUS]) begin
        sample = ddc_reverse(word);
      end
      // Internal arithmetic is two's complement
      if (!s_r.dpath[ddc_pkg::BIT_TWOS]) begin
        sample = sample ^ ddc_pkg::SIGN_FLIP;
      end
      // Only the gain stage is modelled; the mixer core lives elsewhere
      if (s_r.dpath[ddc_pkg::BIT_MIXER_ENA] &&
          s_r.dpath[ddc_pkg::BIT_MIXER_GAIN]) begin
        sample = ddc_double(sample);
      end
      // Converter takes offset-binary codes
      if (s_r.q_chan) begin
        s_nxt.q_out = sample ^ ddc_pkg::SIGN_FLIP;
      end else begin
        s_nxt.i_out = sample ^ ddc_pkg::SIGN_FLIP;
      end
      s_nxt.q_chan = ~s_r.q_chan;
    end

    // Alarm shutdown or transmit off parks both channels at midscale
    if (s_nxt.shut || !s_nxt.txen) begin
      s_nxt.i_out = ddc_pkg::MIDSCALE_CODE;
      s_nxt.q_out = ddc_pkg::MIDSCALE_CODE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.dpath <= ddc_pkg::RST_DATAPATH_CTRL;
      s_r.scale <= ddc_pkg::RST_SCALE_TX_CTRL;
      s_r.i_out <= ddc_pkg::MIDSCALE_CODE;
      s_r.q_out <= ddc_pkg::MIDSCALE_CODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign dac_i_out           = s_r.i_out;
  assign dac_q_out           = s_r.q_out;
  assign output_shutdown     = s_r.shut;
  assign tx_enable           = s_r.txen;
  assign word_wide_input_sel = s_r.dpath[ddc_pkg::BIT_WORD_WIDE];
  assign four_wire_port_sel  = s_r.dpath[ddc_pkg::BIT_FOUR_WIRE];
  assign mixer_enable        = s_r.dpath[ddc_pkg::BIT_MIXER_ENA];
  assign mixer_gain_6db      = s_r.dpath[ddc_pkg::BIT_MIXER_GAIN];
  // Oscillator bit is independent of mixer enable: coarse mixing needs
  // no oscillator
  assign nco_enable          = s_r.dpath[ddc_pkg::BIT_NCO_ENA];
  assign full_scale_steps    = s_r.steps;

endmodule

// File: design/ddc_sif_port.sv
// Serial programming port slave: 3-wire or 4-wire, 24-bit frames.
// Assumes sclk runs below a quarter of mclk; all pins are resynchronised.
module ddc_sif_port (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        sden_n,
  input  wire logic        sdio_i,
  input  wire logic        four_wire,
  input  wire logic [15:0] rdata,
  output logic             sdio_o,
  output logic             sdio_oe,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             wr_pulse,
  output logic [6:0]       addr,
  output logic [15:0]      wdata
);

  typedef struct packed {
    logic                  sclk_m;
    logic                  sclk_s;
    logic                  sclk_d;
    logic                  sden_m;
    logic                  sden_s;
    logic                  dio_m;
    logic                  dio_s;
    ddc_pkg::ddc_sp_state_t state;
    logic [4:0]            cnt;
    logic [7:0]            head;
    logic                  rd;
    logic [15:0]           shift;
    logic                  wr;
    logic [6:0]            addr;
    logic [15:0]           wdata;
    logic                  dio_o;
    logic                  dio_oe;
    logic                  sdo;
    logic                  sdo_oe;
  } ddc_sp_t;

  ddc_sp_t q_r;
  ddc_sp_t q_nxt;
  logic    rise;
  logic    fall;
  logic    outbit;
  logic [15:0] base;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    q_nxt        = q_r;
    q_nxt.sclk_m = sclk;
    q_nxt.sclk_s = q_r.sclk_m;
    q_nxt.sclk_d = q_r.sclk_s;
    q_nxt.sden_m = sden_n;
    q_nxt.sden_s = q_r.sden_m;
    q_nxt.dio_m  = sdio_i;
    q_nxt.dio_s  = q_r.dio_m;
    q_nxt.wr     = 1'b0;
    rise   = q_r.sclk_s & ~q_r.sclk_d;
    fall   = ~q_r.sclk_s & q_r.sclk_d;
    base   = (q_r.cnt == 5'h00) ? rdata : q_r.shift;
    outbit = base[15];
    if (q_r.sden_s) begin
      // Deselect aborts any partial frame and frees the lines
      q_nxt.state  = ddc_pkg::DDC_SP_IDLE;
      q_nxt.cnt    = 5'h00;
      q_nxt.dio_oe = 1'b0;
      q_nxt.sdo_oe = 1'b0;
    end else begin
      case (q_r.state)
        ddc_pkg::DDC_SP_IDLE: begin
          q_nxt.state = ddc_pkg::DDC_SP_HEAD;
          q_nxt.cnt   = 5'h00;
        end
        ddc_pkg::DDC_SP_HEAD: begin
          if (rise) begin
            q_nxt.head = {q_r.head[6:0], q_r.dio_s};
            q_nxt.cnt  = q_r.cnt + ddc_pkg::CNT_ONE;
            if (q_r.cnt == ddc_pkg::HEAD_LAST_BIT) begin
              q_nxt.rd    = q_r.head[6];
              q_nxt.addr  = {q_r.head[5:0], q_r.dio_s};
              q_nxt.state = ddc_pkg::DDC_SP_DATA;
              q_nxt.cnt   = 5'h00;
            end
          end
        end
        ddc_pkg::DDC_SP_DATA: begin
          if (q_r.rd && fall) begin
            // First falling edge loads the addressed register
            q_nxt.shift = {base[14:0], 1'b0};
            if (four_wire) begin
              q_nxt.sdo    = outbit;
              q_nxt.sdo_oe = 1'b1;
            end else begin
              q_nxt.dio_o  = outbit;
              q_nxt.dio_oe = 1'b1;
            end
          end
          if (rise) begin
            q_nxt.cnt = q_r.cnt + ddc_pkg::CNT_ONE;
            if (!q_r.rd) begin
              q_nxt.shift = {q_r.shift[14:0], q_r.dio_s};
            end
            if (q_r.cnt == ddc_pkg::DATA_LAST_BIT) begin
              q_nxt.state = ddc_pkg::DDC_SP_DONE;
              if (!q_r.rd) begin
                q_nxt.wr    = 1'b1;
                q_nxt.wdata = {q_r.shift[14:0], q_r.dio_s};
              end
            end
          end
        end
        default: begin
          // Extra clocks after a full frame are ignored
          q_nxt.state = ddc_pkg::DDC_SP_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_r        <= '0;
      q_r.sden_m <= 1'b1;
      q_r.sden_s <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sdio_o   = q_r.dio_o;
  assign sdio_oe  = q_r.dio_oe;
  assign sdo      = q_r.sdo;
  assign sdo_oe   = q_r.sdo_oe;
  assign wr_pulse = q_r.wr;
  assign addr     = q_r.addr;
  assign wdata    = q_r.wdata;

endmodule

// File: include/ddc_pkg.sv
// Constants shared by the datapath configuration bank and its serial port.
// Assumes a single 40 MHz mclk domain; serial pins are asynchronous to it.
package ddc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, 7-bit serial address space
  localparam logic [6:0]  ADR_DATAPATH_CTRL   = 7'h02;
  localparam logic [6:0]  ADR_SCALE_TX_CTRL   = 7'h03;

  // Reset values
  localparam logic [15:0] RST_DATAPATH_CTRL   = 16'h7000;
  localparam logic [15:0] RST_SCALE_TX_CTRL   = 16'hF000;

  // Writable bits; the rest are reserved and keep their reset value
  localparam logic [15:0] WMASK_DATAPATH_CTRL = 16'hF0FA;
  localparam logic [15:0] WMASK_SCALE_TX_CTRL = 16'hF001;

  // Field positions of datapath_interface_control
  localparam int BIT_WORD_WIDE      = 15;
  localparam int BIT_DACCLK_SHUT    = 14;
  localparam int BIT_DATACLK_SHUT   = 13;
  localparam int BIT_COLLISION_SHUT = 12;
  localparam int BIT_FOUR_WIRE      = 7;
  localparam int BIT_MIXER_ENA      = 6;
  localparam int BIT_MIXER_GAIN     = 5;
  localparam int BIT_NCO_ENA        = 4;
  localparam int BIT_REV_BUS        = 3;
  localparam int BIT_TWOS           = 1;

  // Field positions of output_scale_transmit_control
  localparam int BIT_SCALE_HI       = 15;
  localparam int BIT_SCALE_LO       = 12;
  localparam int BIT_SIF_TXENA      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Sample codes
  localparam logic [15:0] MIDSCALE_CODE  = 16'h8000;
  localparam logic [15:0] SIGN_FLIP      = 16'h8000;
  localparam logic [15:0] POS_FULL       = 16'h7FFF;
  localparam logic [15:0] NEG_FULL       = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame: 1 read/write bit, 7 address bits, 16 data bits, MSB first
  localparam logic [4:0]  HEAD_LAST_BIT  = 5'h07;
  localparam logic [4:0]  DATA_LAST_BIT  = 5'h0F;
  localparam logic [4:0]  CNT_ONE        = 5'h01;

  typedef enum logic [1:0] {
    DDC_SP_IDLE,
    DDC_SP_HEAD,
    DDC_SP_DATA,
    DDC_SP_DONE
  } ddc_sp_state_t;

endpackage

// File: sim/ddc_config_bank_props.sv
// Port checker for the configuration bank: shutdown, transmit, serial port.
// Assumes one mclk domain; bound to every instance of the bank.
module ddc_config_bank_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        sif_sden_n,
  input wire logic        sif_sdio_oe,
  input wire logic        sif_sdo_oe,
  input wire logic        txenable_pin,
  input wire logic        dacclk_gone,
  input wire logic        dataclk_gone,
  input wire logic        fifo_collision,
  input wire logic [15:0] dac_i_out,
  input wire logic [15:0] dac_q_out,
  input wire logic        output_shutdown,
  input wire logic        tx_enable,
  input wire logic        word_wide_input_sel,
  input wire logic        four_wire_port_sel,
  input wire logic        mixer_enable,
  input wire logic        mixer_gain_6db,
  input wire logic        nco_enable,
  input wire logic [4:0]  full_scale_steps
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic any_alarm;
  assign any_alarm = dacclk_gone | dataclk_gone | fifo_collision;

  ////////////////////////////////////////////////////////////////////////////
  chk_tx_pin_on:
    assert property (txenable_pin [*5] |-> tx_enable)
    else $error("tx_enable low while pin held high");
  chk_shut_mid:
    assert property (output_shutdown [*2] |->
      dac_i_out == ddc_pkg::MIDSCALE_CODE && dac_q_out == 16'h8000)
    else $error("outputs not midscale during shutdown");
  chk_tx_off_mid:
    assert property (!tx_enable [*2] |->
      dac_i_out == 16'h8000 && dac_q_out == 16'h8000)
    else $error("outputs not midscale with transmit off");
  chk_shut_cause:
    assert property ($rose(output_shutdown) |-> $past(any_alarm))
    else $error("shutdown rose without an alarm");
  chk_shut_drop:
    assert property (!any_alarm |=> !output_shutdown)
    else $error("shutdown held with no alarm");
  chk_oe_idle:
    assert property (sif_sden_n [*6] |-> !sif_sdio_oe && !sif_sdo_oe)
    else $error("serial output enabled while deselected");
  chk_oe_mode:
    assert property ((sif_sdio_oe |-> !four_wire_port_sel) and
      (sif_sdo_oe |-> four_wire_port_sel))
    else $error("read data on the wrong serial pin");
  chk_cfg_quiet:
    assert property (sif_sden_n [*8] |=> $stable({word_wide_input_sel,
      four_wire_port_sel, mixer_enable, mixer_gain_6db, nco_enable,
      full_scale_steps}))
    else $error("configuration changed with no frame");
endmodule

bind ddc_config_bank ddc_config_bank_props u_props (
  .mclk(mclk), .rst_n(rst_n), .sif_sden_n(sif_sden_n),
  .sif_sdio_oe(sif_sdio_oe), .sif_sdo_oe(sif_sdo_oe),
  .txenable_pin(txenable_pin), .dacclk_gone(dacclk_gone),
  .dataclk_gone(dataclk_gone), .fifo_collision(fifo_collision),
  .dac_i_out(dac_i_out), .dac_q_out(dac_q_out),
  .output_shutdown(output_shutdown), .tx_enable(tx_enable),
  .word_wide_input_sel(word_wide_input_sel),
  .four_wire_port_sel(four_wire_port_sel), .mixer_enable(mixer_enable),
  .mixer_gain_6db(mixer_gain_6db), .nco_enable(nco_enable),
  .full_scale_steps(full_scale_steps));

// File: sim/ddc_config_bank_test.sv
// Self-checking bench for the datapath configuration bank.
// Assumes the host model drives the serial port; one 40 MHz clock.
module ddc_config_bank_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst_n, txenable_pin, dacclk_gone, dataclk_gone;
  logic        fifo_collision, data_strobe, frame_start, fw;
  logic        sclk, sden_n, sdio_i, sdio_o, sdio_oe, sdo, sdo_oe;
  logic        output_shutdown, tx_enable, wwide, fwire, mix, gain, nco;
  logic [4:0]  steps;
  logic [15:0] data_bus, dac_i_out, dac_q_out, q, cur2, cur3, ex;
  logic [22:0] rows [7];
  logic [47:0] smp [9];
  int          errors, n_compared;
  // Two byte-wide words: I then Q
  localparam logic [31:0] IQ_BYTES = 32'h0102F0F0;

  ddc_config_bank u_dut (
    .mclk(mclk), .rst_n(rst_n), .sif_sclk(sclk), .sif_sden_n(sden_n),
    .sif_sdio_i(sdio_i), .sif_sdio_o(sdio_o), .sif_sdio_oe(sdio_oe),
    .sif_sdo(sdo), .sif_sdo_oe(sdo_oe), .txenable_pin(txenable_pin),
    .dacclk_gone(dacclk_gone), .dataclk_gone(dataclk_gone),
    .fifo_collision(fifo_collision), .data_bus(data_bus),
    .data_strobe(data_strobe), .frame_start(frame_start),
    .dac_i_out(dac_i_out), .dac_q_out(dac_q_out),
    .output_shutdown(output_shutdown), .tx_enable(tx_enable),
    .word_wide_input_sel(wwide), .four_wire_port_sel(fwire),
    .mixer_enable(mix), .mixer_gain_6db(gain), .nco_enable(nco),
    .full_scale_steps(steps));
  ddc_host_model u_host (.sclk(sclk), .sden_n(sden_n), .sdio_line(sdio_i),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo(sdo), .sdo_oe(sdo_oe),
    .four_wire(fw));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] keep(input logic [15:0] d, m, r);
    return (d & m) | (r & ~m);
  endfunction
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_host.xfer(1'b0, a, d, q);
    if (a == 7'h02) cur2 = keep(d, ddc_pkg::WMASK_DATAPATH_CTRL, 16'h7000);
    if (a == 7'h03) cur3 = keep(d, ddc_pkg::WMASK_SCALE_TX_CTRL, 16'hF000);
    // Mode takes effect from the next frame on
    fw = cur2[7];
  endtask
  task automatic rdchk(input logic [6:0] a);
    u_host.xfer(1'b1, a, 16'h0000, q);
    check(q, a == 7'h02 ? cur2 : a == 7'h03 ? cur3 : 16'h0000, "read");
  endtask
  task automatic do_reset();
    @(posedge mclk);
    txenable_pin <= 1'b0;
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    fw = 1'b0;
    cur2 = 16'h7000;
    cur3 = 16'hF000;
    check({11'h000, steps}, 16'h0010, "reset steps");
    rdchk(7'h02);
    rdchk(7'h03);
  endtask
  task automatic sample(input logic [47:0] r);
    wr(7'h02, r[47:32]);
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
    data_strobe <= 1'b1;
    // Byte-wide input sends the high byte first on bits 7:0
    data_bus <= r[47] ? r[31:16] : {8'h00, r[31:24]};
    if (!r[47]) begin
      @(posedge mclk);
      data_bus <= {8'h00, r[23:16]};
    end
    @(posedge mclk);
    data_strobe <= 1'b0;
    repeat (2) @(posedge mclk);
    check(dac_i_out, r[15:0], "sample");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    summarize();
  end
  initial begin
    {rst_n, txenable_pin, dacclk_gone, dataclk_gone, fifo_collision} = '0;
    {data_strobe, frame_start, fw, errors, n_compared} = '0;
    data_bus = 16'h0000;
    rows = '{{7'h02, 16'h0000}, {7'h02, 16'hFFFF}, {7'h03, 16'h0000},
             {7'h03, 16'h5A5B}, {7'h05, 16'h1234}, {7'h02, 16'h8F7A},
             {7'h03, 16'hF001}};
    smp = '{{16'h8002, 16'h1234, 16'h9234}, {16'h8000, 16'h1234, 16'h1234},
            {16'h8008, 16'h0003, 16'hC000}, {16'h800A, 16'h0003, 16'h4000},
            {16'h8062, 16'h1000, 16'hA000}, {16'h8062, 16'h7000, 16'hFFFF},
            {16'h8062, 16'h9000, 16'h0000}, {16'h8042, 16'h1000, 16'h9000},
            {16'h0002, 16'h1234, 16'h9234}};
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i][22:16], rows[i][15:0]);
      rdchk(rows[i][22:16]);
      ex = {cur2[15], cur2[7], cur2[6:4], {1'b0, cur3[15:12]} + 5'h01, 6'h00};
      check({wwide, fwire, mix, gain, nco, steps, 6'h00}, ex, "outs");
    end
    foreach (smp[i]) sample(smp[i]);
    // Byte-wide two's complement: second word of a frame feeds Q
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
    data_strobe <= 1'b1;
    for (int b = 3; b >= 0; b--) begin
      data_bus <= {8'h00, IQ_BYTES[8*b +: 8]};
      @(posedge mclk);
    end
    data_strobe <= 1'b0;
    repeat (2) @(posedge mclk);
    check(dac_i_out, 16'h8102, "i chan");
    check(dac_q_out, 16'h70F0, "q chan");
    for (int j = 0; j < 6; j++) begin
      wr(7'h02, j[0] ? (16'h4000 >> j[2:1]) : 16'h0000);
      @(posedge mclk);
      {dacclk_gone, dataclk_gone, fifo_collision} <= 3'b100 >> j[2:1];
      repeat (4) @(posedge mclk);
      check({15'h0000, output_shutdown}, {15'h0000, j[0]}, "shut");
      if (j[0]) check(dac_i_out, 16'h8000, "shut code");
      {dacclk_gone, dataclk_gone, fifo_collision} <= 3'b000;
      repeat (4) @(posedge mclk);
      check({15'h0000, output_shutdown}, 16'h0000, "release");
    end
    for (int k = 0; k < 4; k++) begin
      wr(7'h03, 16'hF000 | {15'h0000, k[0]});
      @(posedge mclk);
      txenable_pin <= k[1];
      repeat (6) @(posedge mclk);
      check({15'h0000, tx_enable}, {15'h0000, k[0] | k[1]}, "txena");
    end
    do_reset();
    summarize();
  end
endmodule

// File: sim/ddc_host_model.sv
// Host side of the serial programming port: 24-bit frames, MSB first.
// Assumes the bank samples on sclk rise and drives read bits after falls.
module ddc_host_model (
  output logic      sclk,
  output logic      sden_n,
  output logic      sdio_line,
  input  wire logic sdio_o,
  input  wire logic sdio_oe,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  input  wire logic four_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // 2.5 MHz serial clock, well inside the resync margin of the bank
  localparam time HALF = 200ns;
  logic drv = 1'b1;
  logic bit_q = 1'b0;
  // Released line shows the inverse of its last level, never a stale copy
  assign sdio_line = sdio_oe ? sdio_o : (drv ? bit_q : ~bit_q);
  // No mask register here; alarms reach shutdown gated by the bank's shutdown enable bits
  initial begin
    sclk = 1'b0;
    sden_n = 1'b1;
  end

  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 16'h0000;
    drv <= 1'b1;
    sden_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      bit_q <= f[i];
      if (rd && i < 16) drv <= 1'b0;
      #HALF sclk <= 1'b1;
      // An undriven data-out pin reads inverted, so a missing enable shows
      if (rd && i < 16) begin
        q[i] = four_wire ? (sdo_oe ? sdo : ~sdo) : sdio_line;
      end
      #HALF sclk <= 1'b0;
    end
    drv <= 1'b1;
    #HALF sden_n <= 1'b1;
    #(4 * HALF);
  endtask
endmodule
